// file: design/cmo_pkg.sv
// Shared constants and types for the message object page and bit timing slice
package cmo_pkg;
    // Special function register offsets
    localparam logic [7:0] OFF_GCTL = 8'hAB;
    localparam logic [7:0] OFF_PAGE = 8'hB1;
    localparam logic [7:0] OFF_STATUS = 8'hB2;
    localparam logic [7:0] OFF_CTRL_LEN = 8'hB3;
    localparam logic [7:0] OFF_BT_PHASE = 8'hB6;
    localparam logic [7:0] OFF_DATA = 8'hA3;
    localparam logic [7:0] OFF_EN_LO = 8'hA4;
    localparam logic [7:0] OFF_EN_HI = 8'hA5;
    ////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int OBJ_NUM = 15;
    localparam int OBJ_W = 4;
    localparam int IDX_W = 3;
    localparam int BUF_BYTES = 8;
    localparam logic [3:0] OBJ_LAST = 4'hE;
    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int PG_OBJ_LSB = 4;
    localparam int PG_HOLD_BIT = 3;
    localparam int BT_PH2_LSB = 4;
    localparam int BT_PH1_LSB = 1;
    localparam int BT_SMP_BIT = 0;
    localparam int BT_RSVD_BIT = 7;
    localparam int CL_ROLE_LSB = 6;
    localparam int CL_REPLY_VALID_BIT = 5;
    localparam int CL_IDE_BIT = 4;
    localparam int ST_LENW_BIT = 7;
    localparam int GC_ON_BIT = 1;
    ////////////////////////////////////////////////////////////////////////
    // Reset values and limits
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [6:0] BT_RST = 7'h00;
    localparam logic [3:0] DLC_MAX = 4'h8;
    localparam logic [2:0] INFO_PH2_MIN = 3'h1;
    localparam int PROP_TQ_DEF = 1;
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        ROLE_OFF,
        ROLE_TX,
        ROLE_RX,
        ROLE_RXBUF
    } cmo_role_e;

    typedef enum logic [1:0] {
        SEG_SYNC,
        SEG_PROP,
        SEG_PH1,
        SEG_PH2
    } cmo_seg_e;

    typedef enum logic [2:0] {
        H_IDLE,
        H_OFF,
        H_ACC,
        H_WAIT,
        H_CAP,
        H_ON
    } cmo_host_e;
endpackage

// file: design/cmo_sfr_if.sv
// Register port between the controller slice and software
`timescale 1ns/1ps
`default_nettype none
interface cmo_sfr_if;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport dev (input addr, input wr, input rd, input wdata, output rdata);
    modport host (output addr, output wr, output rd, output wdata,
                  input rdata);
endinterface
`default_nettype wire

// file: design/cmo_device.sv
// Controller end: page, object control, length, data buffer, bit timer
`timescale 1ns/1ps
`default_nettype none

// Function
// [RULE_01] Phase two lasts field plus one clocks
// [RULE_02] Phase one lasts field plus one clocks
// [RULE_03] Software keeps phase two long enough
// [RULE_04] Sample mode picks one or three samples
// [RULE_05] Timing touched only while controller off
// [RULE_06] Timing bit 7 reserved, never written one
// [RULE_07] Page selects object zero to fourteen
// [RULE_08] Index advances unless hold bit set
// [RULE_09] Index picks byte of object buffer
// [RULE_10] Role field: off, transmit, receive, buffer
// [RULE_11] Role rewrite sets object enable bit
// [RULE_12] Reply valid bit marks reply ready
// [RULE_13] Format bit picks 11 or 29 bits
// [RULE_14] Length code valid from zero to eight
// [RULE_15] Received frame overwrites length code
// [RULE_16] Length mismatch raises a warning
// [RULE_17] Warning sits in status bit 7
// [RULE_18] Index wraps from seven to zero
module cmo_device
    import cmo_pkg::*;
#(
    parameter int PROP_TQ = PROP_TQ_DEF
) (
    input wire logic core_clk,
    input wire logic reset,
    cmo_sfr_if.dev sfr,
    input wire logic can_rx,
    input wire logic rx_done,
    input wire logic [OBJ_W-1:0] rx_obj,
    input wire logic [3:0] rx_dlc,
    output logic sample_bit_q,
    output logic sample_stb_q,
    output logic [OBJ_NUM-1:0] obj_enable_q,
    output logic [OBJ_NUM-1:0] obj_ide_q,
    output logic [OBJ_NUM-1:0] reply_ready_q
);
    localparam logic [3:0] PROP_LAST = 4'(PROP_TQ - 1);

    logic [7:0] page_q;
    logic [7:0] page_d;
    logic [6:0] bt_q;
    logic ctrl_on_q;
    logic [1:0] role_q [OBJ_NUM];
    logic [3:0] dlc_q [OBJ_NUM];
    logic [OBJ_NUM-1:0] lenw_q;
    logic [7:0] buf_q [OBJ_NUM][BUF_BYTES];
    cmo_seg_e seg_q;
    cmo_seg_e seg_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic ext_q;
    logic ext_d;
    logic [1:0] hist_q;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    wire [OBJ_W-1:0] obj = page_q[PG_OBJ_LSB +: OBJ_W];
    wire [IDX_W-1:0] idx = page_q[IDX_W-1:0];
    wire idx_hold = page_q[PG_HOLD_BIT];
    wire obj_ok = obj <= OBJ_LAST; // see [RULE_07]
    wire any_acc = sfr.wr | sfr.rd;
    wire wr_page = sfr.wr && sfr.addr == OFF_PAGE;
    wire wr_bt = sfr.wr && sfr.addr == OFF_BT_PHASE;
    wire wr_gctl = sfr.wr && sfr.addr == OFF_GCTL;
    wire wr_ctl = sfr.wr && sfr.addr == OFF_CTRL_LEN && obj_ok;
    wire wr_sts = sfr.wr && sfr.addr == OFF_STATUS && obj_ok;
    wire data_acc = any_acc && sfr.addr == OFF_DATA && obj_ok;
    wire wr_data = data_acc && sfr.wr;
    // Written lengths above eight are saturated; received lengths are stored unchanged
    wire [3:0] wr_dlc = (sfr.wdata[3:0] > DLC_MAX) ? DLC_MAX
                                                   : sfr.wdata[3:0];
    wire [1:0] wr_role = sfr.wdata[CL_ROLE_LSB +: 2];

    ////////////////////////////////////////////////////////////////////////
    // Read selection
    wire [7:0] ctl_rd = obj_ok ? {role_q[obj], reply_ready_q[obj],
                                  obj_ide_q[obj], dlc_q[obj]} : 8'h00;
    wire [7:0] sts_rd = obj_ok ? {lenw_q[obj], 7'h00} : 8'h00; // see [RULE_17]
    wire [7:0] dat_rd = obj_ok ? buf_q[obj][idx] : 8'h00; // see [RULE_09]
    wire [15:0] en_rd = {1'b0, obj_enable_q};
    // Reserved timing bit reads as zero, no store behind it
    wire [7:0] bt_rd = {1'b0, bt_q}; // see [RULE_06]
    wire [7:0] gctl_rd = 8'(ctrl_on_q) << GC_ON_BIT;
    wire [7:0] rd_mux =
        (sfr.addr == OFF_PAGE) ? page_q :
        (sfr.addr == OFF_BT_PHASE) ? bt_rd :
        (sfr.addr == OFF_GCTL) ? gctl_rd :
        (sfr.addr == OFF_CTRL_LEN) ? ctl_rd :
        (sfr.addr == OFF_STATUS) ? sts_rd :
        (sfr.addr == OFF_DATA) ? dat_rd :
        (sfr.addr == OFF_EN_LO) ? en_rd[7:0] :
        (sfr.addr == OFF_EN_HI) ? en_rd[15:8] : 8'h00;

    // Index moves after each data access to objects 0 to 14 unless held; 3 bits wrap 7 to 0
    always_comb begin
        page_d = page_q;
        if (wr_page) begin
            page_d = sfr.wdata;
        end else if (data_acc && !idx_hold) begin // see [RULE_08]
            page_d[IDX_W-1:0] = idx + 3'h1; // see [RULE_18]
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            page_q <= PAGE_RST;
            bt_q <= BT_RST;
            ctrl_on_q <= 1'b0;
            sfr.rdata <= 8'h00;
        end else begin
            page_q <= page_d;
            if (wr_bt) begin
                bt_q <= sfr.wdata[6:0];
            end
            if (wr_gctl) begin
                ctrl_on_q <= sfr.wdata[GC_ON_BIT];
            end
            if (sfr.rd) begin
                sfr.rdata <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-object state
    for (genvar g = 0; g < OBJ_NUM; g++) begin : g_obj
        wire sel = obj == OBJ_W'(g);
        wire rx_hit = rx_done && rx_obj == OBJ_W'(g);

        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                role_q[g] <= ROLE_OFF;
                reply_ready_q[g] <= 1'b0;
                obj_ide_q[g] <= 1'b0;
                dlc_q[g] <= 4'h0;
                obj_enable_q[g] <= 1'b0;
            end else begin
                if (wr_ctl && sel) begin
                    role_q[g] <= wr_role; // see [RULE_10]
                    // Only a write of the role field moves the enable bit
                    obj_enable_q[g] <= wr_role != ROLE_OFF; // see [RULE_11]
                    reply_ready_q[g] <= sfr.wdata[CL_REPLY_VALID_BIT]; // see [RULE_12]
                    obj_ide_q[g] <= sfr.wdata[CL_IDE_BIT]; // see [RULE_13]
                    dlc_q[g] <= wr_dlc; // see [RULE_14]
                end
                if (rx_hit) begin
                    dlc_q[g] <= rx_dlc; // see [RULE_15]
                end
            end
        end

        // Set from a frame wins over a clear written in the same cycle
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                lenw_q[g] <= 1'b0;
            end else if (rx_hit && rx_dlc != dlc_q[g]) begin
                lenw_q[g] <= 1'b1; // see [RULE_16]
            end else if (wr_sts && sel) begin
                lenw_q[g] <= sfr.wdata[ST_LENW_BIT];
            end
        end

        // Buffer has no reset; contents are undefined until written
        always_ff @(posedge core_clk) begin
            if (wr_data && sel) begin
                buf_q[g][idx] <= sfr.wdata; // see [RULE_09]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit timer, one time quantum per clock since no prescaler here
    wire [2:0] ph1 = bt_q[BT_PH1_LSB +: 3];
    wire [2:0] ph2 = bt_q[BT_PH2_LSB +: 3];
    wire rx_edge = hist_q[0] & ~can_rx;
    wire ph1_end = cnt_q == ({1'b0, ph1} + {3'h0, ext_q});
    wire ph2_end = cnt_q == {1'b0, ph2};
    wire vote = (hist_q[1] & hist_q[0]) | (hist_q[1] & can_rx) |
                (hist_q[0] & can_rx);
    wire at_sample = seg_q == SEG_PH1 && ph1_end;

    always_comb begin
        seg_d = seg_q;
        cnt_d = cnt_q + 4'h1;
        ext_d = ext_q;
        if (!ctrl_on_q) begin
            seg_d = SEG_SYNC;
            cnt_d = 4'h0;
            ext_d = 1'b0;
        end else begin
            unique case (seg_q)
                SEG_SYNC: begin
                    seg_d = SEG_PROP;
                    cnt_d = 4'h0;
                end
                SEG_PROP: begin
                    if (cnt_q == PROP_LAST) begin
                        seg_d = SEG_PH1;
                        cnt_d = 4'h0;
                    end
                end
                SEG_PH1: begin
                    // Resync edge stretches phase one by one quantum
                    if (rx_edge && !ext_q) begin
                        ext_d = 1'b1; // see [RULE_02]
                    end
                    if (ph1_end) begin
                        seg_d = SEG_PH2;
                        cnt_d = 4'h0;
                        ext_d = 1'b0;
                    end
                end
                SEG_PH2: begin
                    // Resync edge cuts phase two short
                    if (ph2_end || rx_edge) begin // see [RULE_01]
                        seg_d = SEG_SYNC;
                        cnt_d = 4'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            seg_q <= SEG_SYNC;
            cnt_q <= 4'h0;
            ext_q <= 1'b0;
            hist_q <= 2'h3;
            sample_stb_q <= 1'b0;
            sample_bit_q <= 1'b1;
        end else begin
            seg_q <= seg_d;
            cnt_q <= cnt_d;
            ext_q <= ext_d;
            hist_q <= {hist_q[0], can_rx};
            sample_stb_q <= at_sample;
            if (at_sample) begin
                sample_bit_q <= bt_q[BT_SMP_BIT] ? vote : can_rx; // see [RULE_04]
            end
        end
    end
endmodule
`default_nettype wire

// file: design/cmo_host.sv
// Software end: command port driving the controller registers safely
`timescale 1ns/1ps
`default_nettype none
module cmo_host
    import cmo_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    cmo_sfr_if.host sfr,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    output logic cmd_ready_q,
    output logic rsp_valid_q,
    output logic [7:0] rsp_data_q
);
    cmo_host_e st_q;
    cmo_host_e st_d;
    logic [7:0] addr_q;
    logic [7:0] wdata_q;
    logic write_q;
    logic restore_q;
    logic gctl_on_q;

    wire take = cmd_valid && st_q == H_IDLE;
    wire is_bt = cmd_addr == OFF_BT_PHASE;
    // Timing registers are only touched with the controller off
    wire need_off = is_bt && gctl_on_q; // see [RULE_05]

    ////////////////////////////////////////////////////////////////////////
    // Sanitise written values
    wire [2:0] ph1 = wdata_q[BT_PH1_LSB +: 3];
    wire [2:0] ph2 = wdata_q[BT_PH2_LSB +: 3];
    wire [2:0] ph2_floor = (ph1 > INFO_PH2_MIN) ? ph1 : INFO_PH2_MIN;
    wire [2:0] ph2_fix = (ph2 < ph2_floor) ? ph2_floor : ph2; // see [RULE_03]
    wire [7:0] bt_w = {1'b0, ph2_fix, wdata_q[3:0]}; // see [RULE_06]
    wire [3:0] dlc_fix = (wdata_q[3:0] > DLC_MAX) ? DLC_MAX : wdata_q[3:0];
    // Role is always rewritten in full so the enable bit follows it
    wire [7:0] ctl_w = {wdata_q[7:4], dlc_fix}; // see [RULE_11] [RULE_14]
    wire [7:0] acc_w = (addr_q == OFF_BT_PHASE) ? bt_w :
                       (addr_q == OFF_CTRL_LEN) ? ctl_w : wdata_q;
    wire [7:0] gctl_off = 8'h00;
    wire [7:0] gctl_on = 8'(1'b1) << GC_ON_BIT;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            H_IDLE: begin
                if (cmd_valid) begin
                    st_d = need_off ? H_OFF : H_ACC;
                end
            end
            H_OFF: st_d = H_ACC;
            H_ACC: st_d = write_q ? (restore_q ? H_ON : H_IDLE) : H_WAIT;
            H_WAIT: st_d = H_CAP;
            H_CAP: st_d = restore_q ? H_ON : H_IDLE;
            H_ON: st_d = H_IDLE;
        endcase
    end

    wire done = st_d == H_IDLE && st_q != H_IDLE;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_q <= H_IDLE;
            addr_q <= 8'h00;
            wdata_q <= 8'h00;
            write_q <= 1'b0;
            restore_q <= 1'b0;
            gctl_on_q <= 1'b0;
            cmd_ready_q <= 1'b1;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 8'h00;
            sfr.addr <= 8'h00;
            sfr.wr <= 1'b0;
            sfr.rd <= 1'b0;
            sfr.wdata <= 8'h00;
        end else begin
            st_q <= st_d;
            cmd_ready_q <= st_d == H_IDLE;
            rsp_valid_q <= done;
            sfr.wr <= 1'b0;
            sfr.rd <= 1'b0;
            if (take) begin
                addr_q <= cmd_addr;
                wdata_q <= cmd_wdata;
                write_q <= cmd_write;
                restore_q <= need_off;
                if (cmd_write && cmd_addr == OFF_GCTL) begin
                    gctl_on_q <= cmd_wdata[GC_ON_BIT];
                end
            end
            unique case (st_q)
                H_OFF: begin
                    sfr.addr <= OFF_GCTL;
                    sfr.wdata <= gctl_off;
                    sfr.wr <= 1'b1;
                end
                H_ACC: begin
                    sfr.addr <= addr_q;
                    sfr.wdata <= acc_w;
                    sfr.wr <= write_q;
                    sfr.rd <= !write_q;
                end
                H_CAP: rsp_data_q <= sfr.rdata;
                H_ON: begin
                    sfr.addr <= OFF_GCTL;
                    sfr.wdata <= gctl_on;
                    sfr.wr <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: test/cmo_sfr_props.sv
// Concurrent checks on the register port between host and device
`timescale 1ns/1ps
`default_nettype none
module cmo_sfr_props
    import cmo_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////
    // Shadow state rebuilt from bus traffic alone
    logic on_q;
    logic [7:0] pg_q;
    logic [7:0] pg_d;
    logic [6:0] bt_q;
    wire w_b6 = wr && addr == OFF_BT_PHASE;
    // Object 15 does not exist, so its data access must not move the index
    wire dat_acc = (wr || rd) && addr == OFF_DATA && pg_q[7:4] != 4'hF;
    wire idx_go = dat_acc && !pg_q[PG_HOLD_BIT];
    assign pg_d = (wr && addr == OFF_PAGE) ? wdata
        : idx_go ? {pg_q[7:3], pg_q[2:0] + 3'h1} : pg_q;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            on_q <= 1'b0;
            pg_q <= PAGE_RST;
            bt_q <= BT_RST;
        end else begin
            on_q <= (wr && addr == OFF_GCTL) ? wdata[GC_ON_BIT] : on_q;
            pg_q <= pg_d;
            bt_q <= w_b6 ? wdata[6:0] : bt_q;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_rsvd_bit_clear: assert property (
        w_b6 |-> !wdata[BT_RSVD_BIT]) else $error("reserved bit written");
    a_ph2_long_enough: assert property (
        w_b6 |-> wdata[6:4] >= wdata[3:1] && wdata[6:4] >= INFO_PH2_MIN)
        else $error("phase two too short");
    a_timing_while_off: assert property (
        (wr || rd) && addr == OFF_BT_PHASE |-> !on_q)
        else $error("timing touched while on");
    a_dlc_in_range: assert property (
        wr && addr == OFF_CTRL_LEN |-> wdata[3:0] <= DLC_MAX)
        else $error("length code above eight");
    a_page_tracks: assert property (
        rd && addr == OFF_PAGE |=> rdata == $past(pg_q))
        else $error("page readback differs");
    a_timing_readback: assert property (
        rd && addr == OFF_BT_PHASE |=> rdata == {1'b0, $past(bt_q)})
        else $error("timing readback differs");
    a_status_bits: assert property (
        rd && addr == OFF_STATUS |=> rdata[6:0] == 7'h00)
        else $error("status low bits set");
    a_no_obj_fifteen: assert property (
        rd && addr == OFF_EN_HI |=> !rdata[7])
        else $error("enable bit for object 15");
    a_obj15_data_zero: assert property (
        rd && addr == OFF_DATA && pg_q[7:4] == 4'hF |=> rdata == 8'h00)
        else $error("data from object 15");
endmodule
`default_nettype wire

// file: test/can_msg_object_page_and_bit_timing_tb_top.sv
// Self-checking bench: host and device joined over the register port
`timescale 1ns/1ps
`default_nettype none
module can_msg_object_page_and_bit_timing_tb_top
    import cmo_pkg::*;
;
    localparam int PROP = 2;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [7:0] cmd_addr = 8'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic can_rx = 1'b1;
    logic rx_done = 1'b0;
    logic [3:0] rx_obj = 4'h0;
    logic [3:0] rx_dlc = 4'h0;
    logic cmd_ready_q, rsp_valid_q, sample_bit_q, sample_stb_q;
    logic [7:0] rsp_data_q, q;
    logic [7:0] buf_e [8];
    logic [14:0] obj_enable_q, obj_ide_q, reply_ready_q;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    cmo_sfr_if sfr();
    cmo_host u_cmo_host (.core_clk(core_clk), .reset(reset),
        .sfr(sfr.host), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready_q(cmd_ready_q), .rsp_valid_q(rsp_valid_q),
        .rsp_data_q(rsp_data_q));
    cmo_device #(.PROP_TQ(PROP)) u_cmo_device (.core_clk(core_clk),
        .reset(reset), .sfr(sfr.dev), .can_rx(can_rx), .rx_done(rx_done),
        .rx_obj(rx_obj), .rx_dlc(rx_dlc), .sample_bit_q(sample_bit_q),
        .sample_stb_q(sample_stb_q), .obj_enable_q(obj_enable_q),
        .obj_ide_q(obj_ide_q), .reply_ready_q(reply_ready_q));
    cmo_sfr_props u_cmo_sfr_props (.core_clk(core_clk), .reset(reset),
        .addr(sfr.addr), .wr(sfr.wr), .rd(sfr.rd), .wdata(sfr.wdata),
        .rdata(sfr.rdata));
    ////////////////////////////////////////////////////////////////
    always #5 core_clk = ~core_clk;
    // Whole run needs under a thousand cycles; the ceiling leaves margin
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    // One command at a time: next one only after the response pulse
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_addr = a;
        cmd_wdata = d;
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b0;
        chk("busy", 8'h00, {7'h0, cmd_ready_q});
        n = 0;
        while (rsp_valid_q !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n == 20) err_total++;
        q = rsp_data_q;
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a,
                          input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(n, e, q);
    endtask
    task automatic rx(input logic [3:0] o, input logic [3:0] d);
        @(posedge core_clk);
        #1;
        rx_obj = o;
        rx_dlc = d;
        rx_done = 1'b1;
        @(posedge core_clk);
        #1;
        rx_done = 1'b0;
    endtask
    task automatic stb_gap(output int g);
        g = 0;
        do begin
            @(posedge core_clk);
            #1;
            g++;
        end while (sample_stb_q !== 1'b1 && g < 40);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        int ob, ix, g;
        logic [7:0] v;
        logic [2:0] p1, p2;
        v = 8'($urandom(32'h944B));
        repeat (8) @(posedge core_clk);
        #1;
        reset = 1'b0;
        chk("idle", 8'h05, {5'h0, cmd_ready_q, sample_stb_q, sample_bit_q});
        rd_chk("page", OFF_PAGE, PAGE_RST);
        rd_chk("timing", OFF_BT_PHASE, 8'h00);
        for (int k = 0; k < 3; k++) begin
            ob = (k == 0) ? 14 : $urandom_range(13);
            ix = $urandom_range(7);
            acc(1'b1, OFF_PAGE, {ob[3:0], 1'b0, ix[2:0]});
            for (int b = 0; b < 9; b++) begin
                v = 8'($urandom);
                buf_e[(ix + b) % 8] = v;
                acc(1'b1, OFF_DATA, v);
            end
            rd_chk("index", OFF_PAGE, {ob[3:0], 1'b0, 3'(ix + 1)});
            acc(1'b1, OFF_PAGE, {ob[3:0], 4'h8});
            rd_chk("held", OFF_DATA, buf_e[0]);
            rd_chk("held", OFF_DATA, buf_e[0]);
            acc(1'b1, OFF_PAGE, {ob[3:0], 4'h0});
            for (int b = 0; b < 8; b++) begin
                rd_chk("byte", OFF_DATA, buf_e[b]);
            end
        end
        acc(1'b1, OFF_PAGE, 8'hF0);
        rd_chk("absent", OFF_DATA, 8'h00);
        rd_chk("page", OFF_PAGE, 8'hF0);
        for (int r = 0; r < 4; r++) begin
            // Fix two objects so both enable registers are read
            ob = (r == 1) ? 0 : (r == 3) ? 14 : $urandom_range(14);
            v = {r[1:0], 6'($urandom)};
            if (r == 3) v[3:0] = 4'hF;
            acc(1'b1, OFF_PAGE, {ob[3:0], 4'h0});
            acc(1'b1, OFF_CTRL_LEN, v);
            if (v[3:0] > DLC_MAX) v[3:0] = DLC_MAX;
            rd_chk("ctrl", OFF_CTRL_LEN, v);
            chk("en", {7'h0, r != 0}, {7'h0, obj_enable_q[ob]});
            chk("ide", {7'h0, v[4]}, {7'h0, obj_ide_q[ob]});
            chk("reply_valid", {7'h0, v[5]}, {7'h0, reply_ready_q[ob]});
            acc(1'b0, (ob < 8) ? OFF_EN_LO : OFF_EN_HI, 8'h00);
            chk("enreg", {7'h0, r != 0}, {7'h0, q[ob % 8]});
            rx(ob[3:0], v[3:0] ^ 4'h1);
            rd_chk("rxlen", OFF_CTRL_LEN, {v[7:4], v[3:0] ^ 4'h1});
            rd_chk("warn", OFF_STATUS, 8'h80);
            // Clear lands on the same edge as a mismatching frame
            fork
                acc(1'b1, OFF_STATUS, 8'h00);
                begin
                    repeat (2) @(posedge core_clk);
                    rx(ob[3:0], v[3:0] ^ 4'h3);
                end
            join
            rd_chk("setwin", OFF_STATUS, 8'h80);
            acc(1'b1, OFF_STATUS, 8'h00);
            rx(ob[3:0], v[3:0] ^ 4'h3);
            rd_chk("nowarn", OFF_STATUS, 8'h00);
        end
        for (int k = 0; k < 4; k++) begin
            p1 = 3'($urandom_range(7));
            p2 = 3'($urandom_range(7, (p1 == 0) ? 1 : p1));
            acc(1'b1, OFF_GCTL, 8'h00);
            can_rx = k[1];
            acc(1'b1, OFF_BT_PHASE, {1'b0, p2, p1, k[0]});
            acc(1'b1, OFF_GCTL, 8'h02);
            rd_chk("timing", OFF_BT_PHASE, {1'b0, p2, p1, k[0]});
            stb_gap(g);
            stb_gap(g);
            chk("bittime", 8'(3 + PROP + p1 + p2), 8'(g));
            chk("sample", {7'h0, k[1]}, {7'h0, sample_bit_q});
            // One-cycle glitch at the next sample point: only a vote hides it
            repeat (2 + PROP + p1 + p2) @(posedge core_clk);
            #1;
            can_rx = ~k[1];
            @(posedge core_clk);
            #1;
            can_rx = k[1];
            chk("vote", {7'h0, k[1] ^ !k[0]}, {7'h0, sample_bit_q});
        end
        conclude();
    end
endmodule
`default_nettype wire
